// ==== shared/tpg_pkg.sv ====
// ****************************************
// pattern generator constants
// ****************************************
`default_nettype none
package tpg_pkg;

  // register byte offsets on the control bus
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WIDTH = 8'h08;
  localparam logic [7:0] REG_HEIGHT = 8'h0c;
  localparam logic [7:0] REG_BG_SEL = 8'h10;
  localparam logic [7:0] REG_OVL_SEL = 8'h14;
  localparam logic [7:0] REG_FORMAT = 8'h18;
  localparam logic [7:0] REG_IN_EN = 8'h1c;
  localparam logic [7:0] REG_CROSS_X = 8'h20;
  localparam logic [7:0] REG_CROSS_Y = 8'h24;
  localparam logic [7:0] REG_SPEED = 8'h28;

  // values after reset, and reset hold length in cycles
  localparam int RST_WIDTH = 64;
  localparam int RST_HEIGHT = 64;
  localparam int RESET_HOLD_CYCLES = 16;

  // background pattern codes
  localparam logic [7:0] PAT_PASS = 8'h00;
  localparam logic [7:0] PAT_HRAMP = 8'h01;
  localparam logic [7:0] PAT_VRAMP = 8'h02;
  localparam logic [7:0] PAT_TRAMP = 8'h03;
  localparam logic [7:0] PAT_RED = 8'h04;
  localparam logic [7:0] PAT_GREEN = 8'h05;
  localparam logic [7:0] PAT_BLUE = 8'h06;
  localparam logic [7:0] PAT_BLACK = 8'h07;
  localparam logic [7:0] PAT_WHITE = 8'h08;
  localparam logic [7:0] PAT_BARS = 8'h09;
  localparam logic [7:0] PAT_ZONE = 8'h0a;
  localparam logic [7:0] PAT_TARTAN = 8'h0b;
  localparam logic [7:0] PAT_HATCH = 8'h0c;
  localparam logic [7:0] PAT_SWEEP = 8'h0d;
  localparam logic [7:0] PAT_HVRAMP = 8'h0e;
  localparam logic [7:0] PAT_CHECK = 8'h0f;
  localparam logic [7:0] PAT_DPRAMP = 8'h11;
  localparam logic [7:0] PAT_DPLINES = 8'h12;
  localparam logic [7:0] PAT_DPSQUARE = 8'h13;

  // overlay codes
  localparam logic [7:0] OVL_NONE = 8'h00;
  localparam logic [7:0] OVL_CROSS = 8'h02;

  // frame sequencer states, gray along idle-gen-pass
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GEN = 2'b01,
    ST_PASS = 2'b11
  } tpg_state_t;

endpackage
`default_nettype wire

// ==== logic/tpg_core.sv ====
// Contract
// - both streams run on core clock
// - control bus runs on core clock
// - reset only by pin, no soft reset
// - reset sampled synchronously to core clock
// - reset clears bus and both streams
// - non-size parameters apply immediately; pass/generate choice from bg and in_en is taken only at frame start
// - generated frames carry own sof/eol
// - pixels per clock 1, 2, 4, 8
// - component width 8, 10, 12, 16
// - max width build-time, width programmable
// - max height build-time, height programmable
// - input stream optional at build time
// - solid colour category optional
// - ramp category optional
// - bar category optional
// - display-link category optional
// - colour sweep category optional
// - zone plate category optional
// - overlay logic optional
// - omitted category yields black frame; the code still draws the cross hair on it when OVL_CROSS is selected
// - no overlay when overlay omitted
// - background zero passes input unchanged; the code needs in_en set and HAS_INPUT, else it generates black
`timescale 1ns/1ns
`default_nettype none
module tpg_core
  import tpg_pkg::*;
#(
  parameter int SPC = 1,
  parameter int DW = 8,
  parameter int MAX_COLS = 4096,
  parameter int MAX_ROWS = 2160,
  parameter bit HAS_INPUT = 1'b1,
  parameter bit HAS_SOLID = 1'b1,
  parameter bit HAS_RAMP = 1'b1,
  parameter bit HAS_BAR = 1'b1,
  parameter bit HAS_DP = 1'b1,
  parameter bit HAS_SWEEP = 1'b1,
  parameter bit HAS_ZONE = 1'b1,
  parameter bit HAS_OVERLAY = 1'b1
) (
  input wire logic core_clock_i,
  input wire logic core_reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic s_axis_tvalid_i,
  output logic s_axis_tready_o,
  input wire logic [SPC*3*DW-1:0] s_axis_tdata_i,
  input wire logic s_axis_tuser_i,
  input wire logic s_axis_tlast_i,
  output logic m_axis_tvalid_o,
  input wire logic m_axis_tready_i,
  output logic [SPC*3*DW-1:0] m_axis_tdata_o,
  output logic m_axis_tuser_o,
  output logic m_axis_tlast_o
);

  // three components per pixel, SPC pixels per beat
  localparam int PW = 3 * DW;
  localparam int TW = SPC * PW;
  localparam int XW = $clog2(MAX_COLS + 1);
  localparam int YW = $clog2(MAX_ROWS + 1);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tpg_state_t st;
    logic ack;
    logic [31:0] dat;
    logic run;
    logic [XW-1:0] width;
    logic [YW-1:0] height;
    logic [XW-1:0] width_act;
    logic [YW-1:0] height_act;
    logic [7:0] bg;
    logic [7:0] ovl;
    logic [1:0] fmt;
    logic in_en;
    logic [XW-1:0] cross_x;
    logic [YW-1:0] cross_y;
    logic [7:0] speed;
    logic [XW-1:0] x;
    logic [YW-1:0] y;
    logic [7:0] frm;
    logic [15:0] fcnt;
    logic tvalid;
    logic [TW-1:0] tdata;
    logic tuser;
    logic tlast;
    logic s_rdy;
  } tpg_regs_t;

  tpg_regs_t r_reg;
  tpg_regs_t r_next;

  // ****************************************
  // pattern functions
  // ****************************************

  // category build switch for a background code
  function automatic logic cat_en(input logic [7:0] code);
    unique case (code)
      PAT_RED, PAT_GREEN, PAT_BLUE, PAT_BLACK, PAT_WHITE:
        cat_en = HAS_SOLID;
      PAT_HRAMP, PAT_VRAMP, PAT_TRAMP, PAT_HVRAMP:
        cat_en = HAS_RAMP;
      PAT_BARS, PAT_TARTAN, PAT_HATCH, PAT_CHECK:
        cat_en = HAS_BAR;
      PAT_DPRAMP, PAT_DPLINES, PAT_DPSQUARE:
        cat_en = HAS_DP;
      PAT_SWEEP: cat_en = HAS_SWEEP;
      PAT_ZONE: cat_en = HAS_ZONE;
      default: cat_en = 1'b0;
    endcase
  endfunction

  // widen an 8-bit level to DW bits
  function automatic logic [DW-1:0] lvl(input logic [7:0] v);
    logic [15:0] w;
    w = {v, v};
    lvl = w[15 -: DW];
  endfunction

  // one pixel of background plus overlay
  function automatic logic [PW-1:0] pix_f(
    input logic [7:0] code,
    input logic [15:0] xx,
    input logic [15:0] yy,
    input logic [7:0] fr,
    input logic ovl_on,
    input logic hit
  );
    logic [7:0] rc;
    logic [7:0] gc;
    logic [7:0] bc;
    logic [15:0] zp;
    rc = 8'h00;
    gc = 8'h00;
    bc = 8'h00;
    zp = 16'(xx[7:0] * xx[7:0]) + 16'(yy[7:0] * yy[7:0]);
    unique case (code)
      PAT_HRAMP: {rc, gc, bc} = {3{xx[7:0]}};
      PAT_VRAMP: {rc, gc, bc} = {3{yy[7:0]}};
      PAT_TRAMP: {rc, gc, bc} = {3{fr}};
      PAT_HVRAMP: {rc, gc, bc} = {3{8'(xx[7:0] + yy[7:0])}};
      PAT_RED: rc = 8'hff;
      PAT_GREEN: gc = 8'hff;
      PAT_BLUE: bc = 8'hff;
      PAT_WHITE: {rc, gc, bc} = {3{8'hff}};
      PAT_BARS: {rc, gc, bc} = {{8{~xx[8]}}, {8{~xx[7]}}, {8{~xx[6]}}};
      PAT_TARTAN: {rc, gc, bc} = {{8{xx[6]}}, {8{yy[6]}}, {8{xx[6]^yy[6]}}};
      PAT_HATCH: {rc, gc, bc} =
        {3{{8{(xx[4:0] == 5'h00) || (yy[4:0] == 5'h00)}}}};
      PAT_CHECK: {rc, gc, bc} = {3{{8{xx[5] ^ yy[5]}}}};
      PAT_SWEEP: {rc, gc, bc} = {xx[7:0], ~xx[7:0], yy[7:0]};
      PAT_ZONE: {rc, gc, bc} = {3{8'(zp[15:8] + fr)}};
      PAT_DPRAMP: {rc, gc, bc} = {xx[7:0], xx[7:0], 8'h00};
      PAT_DPLINES: {rc, gc, bc} = {3{{8{xx[0]}}}};
      PAT_DPSQUARE: {rc, gc, bc} = {{8{xx[6]}}, {8{yy[6]}}, 8'h80};
      default: {rc, gc, bc} = 24'h000000;
    endcase
    // disabled or unknown category gives black
    if (!cat_en(code)) {rc, gc, bc} = 24'h000000;
    // cross hair drawn opaque on top
    if (ovl_on && hit) {rc, gc, bc} = {3{8'hff}};
    pix_f = {lvl(rc), lvl(gc), lvl(bc)};
  endfunction

  // ****************************************
  // per-lane pixel generation
  // ****************************************
  logic ovl_on;
  logic [TW-1:0] gen_data;

  // overlay only exists when built in
  assign ovl_on = HAS_OVERLAY && (r_reg.ovl == OVL_CROSS);

  // one lane per sample of the beat
  genvar gl;
  generate
    for (gl = 0; gl < SPC; gl++)
    begin : g_lane
      logic [15:0] lx;
      assign lx = 16'(r_reg.x) + 16'(gl);
      assign gen_data[gl*PW +: PW] = pix_f(r_reg.bg, lx, 16'(r_reg.y),
        r_reg.frm, ovl_on,
        (lx == 16'(r_reg.cross_x)) || (r_reg.y == r_reg.cross_y));
    end
  endgenerate

  // ****************************************
  // next-state logic
  // ****************************************
  logic bus_req;
  logic [31:0] rd_val;
  logic [31:0] wr_val;
  logic out_free;
  logic eol;
  logic pass_ok;
  logic [7:0] word_adr;

  assign bus_req = wb_cyc_i && wb_stb_i && !r_reg.ack;
  assign word_adr = {wb_adr_i[7:2], 2'b00};
  assign out_free = !r_reg.tvalid || m_axis_tready_i;
  assign eol = (32'(r_reg.x) + 32'(SPC)) >= 32'(r_reg.width_act);
  assign pass_ok = HAS_INPUT && r_reg.in_en && (r_reg.bg == PAT_PASS);

  // register read mux, unmapped reads zero
  always_comb
  begin
    unique case (word_adr)
      REG_CTRL: rd_val = {31'h0, r_reg.run};
      REG_STATUS: rd_val = {r_reg.fcnt, 14'h0, r_reg.st};
      REG_WIDTH: rd_val = 32'(r_reg.width);
      REG_HEIGHT: rd_val = 32'(r_reg.height);
      REG_BG_SEL: rd_val = {24'h0, r_reg.bg};
      REG_OVL_SEL: rd_val = {24'h0, r_reg.ovl};
      REG_FORMAT: rd_val = {30'h0, r_reg.fmt};
      REG_IN_EN: rd_val = {31'h0, r_reg.in_en};
      REG_CROSS_X: rd_val = 32'(r_reg.cross_x);
      REG_CROSS_Y: rd_val = 32'(r_reg.cross_y);
      REG_SPEED: rd_val = {24'h0, r_reg.speed};
      default: rd_val = 32'h0;
    endcase
  end

  // byte-lane merge of write data
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wr_val[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : rd_val[b*8 +: 8];
  end

  always_comb
  begin
    r_next = r_reg;
    // bus slave: answer one cycle after request
    r_next.ack = bus_req;
    if (bus_req)
    begin
      r_next.dat = rd_val;
      if (wb_we_i)
      begin
        // writes take effect at once, no soft reset bit
        unique case (word_adr)
          REG_CTRL: r_next.run = wr_val[0];
          REG_WIDTH: r_next.width = XW'(wr_val);
          REG_HEIGHT: r_next.height = YW'(wr_val);
          REG_BG_SEL: r_next.bg = wr_val[7:0];
          REG_OVL_SEL: r_next.ovl = wr_val[7:0];
          REG_FORMAT: r_next.fmt = wr_val[1:0];
          REG_IN_EN: r_next.in_en = wr_val[0];
          REG_CROSS_X: r_next.cross_x = XW'(wr_val);
          REG_CROSS_Y: r_next.cross_y = YW'(wr_val);
          REG_SPEED: r_next.speed = wr_val[7:0];
          default: r_next.run = r_reg.run;
        endcase
      end
    end
    // output beat leaves when taken
    if (r_reg.tvalid && m_axis_tready_i)
      r_next.tvalid = 1'b0;
    unique case (r_reg.st)
      ST_IDLE:
      begin
        // frame size latched only at frame start
        if (r_reg.run)
        begin
          r_next.width_act = r_reg.width;
          r_next.height_act = r_reg.height;
          r_next.x = '0;
          r_next.y = '0;
          r_next.st = pass_ok ? ST_PASS : ST_GEN;
        end
      end
      ST_GEN:
      begin
        if (out_free)
        begin
          // own frame and line markers
          r_next.tvalid = 1'b1;
          r_next.tdata = gen_data;
          r_next.tuser = (r_reg.x == '0) && (r_reg.y == '0);
          r_next.tlast = eol;
          r_next.x = XW'(32'(r_reg.x) + 32'(SPC));
          if (eol)
          begin
            r_next.x = '0;
            r_next.y = YW'(32'(r_reg.y) + 32'd1);
            if (32'(r_reg.y) + 32'd1 >= 32'(r_reg.height_act))
            begin
              r_next.y = '0;
              r_next.frm = r_reg.frm + r_reg.speed;
              r_next.fcnt = r_reg.fcnt + 16'h0001;
              r_next.st = ST_IDLE;
            end
          end
        end
      end
      ST_PASS:
      begin
        // input beat copied unchanged
        if (s_axis_tvalid_i && r_reg.s_rdy)
        begin
          r_next.tvalid = 1'b1;
          r_next.tdata = s_axis_tdata_i;
          r_next.tuser = s_axis_tuser_i;
          r_next.tlast = s_axis_tlast_i;
          if (s_axis_tlast_i)
          begin
            r_next.y = YW'(32'(r_reg.y) + 32'd1);
            if (32'(r_reg.y) + 32'd1 >= 32'(r_reg.height_act))
            begin
              r_next.y = '0;
              r_next.fcnt = r_reg.fcnt + 16'h0001;
              r_next.st = ST_IDLE;
            end
          end
        end
      end
      // unused code 2'b10 falls back to idle
      default: r_next.st = ST_IDLE;
    endcase
    // input taken only into an empty output slot
    r_next.s_rdy = (r_next.st == ST_PASS) && !r_next.tvalid;
  end

  // ****************************************
  // state register
  // ****************************************

  // synchronous active-low reset of everything
  always_ff @(posedge core_clock_i)
  begin
    if (!core_reset_n_i)
    begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.width <= XW'(RST_WIDTH);
      r_reg.height <= YW'(RST_HEIGHT);
    end
    else
      r_reg <= r_next;
  end

  // outputs straight from the state register
  assign wb_ack_o = r_reg.ack;
  assign wb_dat_o = r_reg.dat;
  assign s_axis_tready_o = r_reg.s_rdy;
  assign m_axis_tvalid_o = r_reg.tvalid;
  assign m_axis_tdata_o = r_reg.tdata;
  assign m_axis_tuser_o = r_reg.tuser;
  assign m_axis_tlast_o = r_reg.tlast;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clock_i); endclocking
  default disable iff (!core_reset_n_i);

  ack_pulse_a: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
  rst_clear_a: assert property (
    !$past(core_reset_n_i) |-> !m_axis_tvalid_o && !s_axis_tready_o
      && !wb_ack_o && r_reg.st == ST_IDLE)
    else $error("reset left state behind");
  hold_out_a: assert property (
    m_axis_tvalid_o && !m_axis_tready_i |=>
      m_axis_tvalid_o && $stable(m_axis_tdata_o) && $stable(m_axis_tlast_o))
    else $error("output beat changed under backpressure");
  sof_mark_a: assert property (
    r_reg.st == ST_GEN && out_free |=>
      m_axis_tuser_o == ($past(r_reg.x) == '0 && $past(r_reg.y) == '0))
    else $error("start of frame marker wrong");
  eol_mark_a: assert property (
    r_reg.st == ST_GEN && out_free |=> m_axis_tlast_o == $past(eol))
    else $error("end of line marker wrong");
  off_black_a: assert property (
    r_reg.st == ST_GEN && out_free && !ovl_on && !cat_en(r_reg.bg)
      |=> m_axis_tdata_o == '0)
    else $error("omitted category not black");
  no_overlay_a: assert property (
    r_reg.st == ST_GEN && out_free && !ovl_on
      && (r_reg.bg == PAT_BLACK || !cat_en(r_reg.bg))
      |=> m_axis_tdata_o == '0)
    else $error("overlay drawn while off");
  pass_copy_a: assert property (
    s_axis_tvalid_i && s_axis_tready_o |=> m_axis_tvalid_o
      && m_axis_tdata_o == $past(s_axis_tdata_i)
      && m_axis_tlast_o == $past(s_axis_tlast_i))
    else $error("pass-through beat altered");
  size_hold_a: assert property (
    r_reg.st != ST_IDLE && $past(r_reg.st) != ST_IDLE |->
      $stable(r_reg.width_act) && $stable(r_reg.height_act))
    else $error("frame size moved mid-frame");
  bg_live_a: assert property (
    bus_req && wb_we_i && word_adr == REG_BG_SEL && wb_sel_i[0]
      |=> r_reg.bg == $past(wb_dat_i[7:0]))
    else $error("background select not applied");

  gen_frame_c: cover property (
    r_reg.st == ST_GEN ##1 r_reg.st == ST_IDLE);
  pass_beat_c: cover property (s_axis_tvalid_i && s_axis_tready_o);
  stall_c: cover property (
    m_axis_tvalid_o && !m_axis_tready_i [*3]);

endmodule // tpg_core
`default_nettype wire

// ==== dv/tpg_stream_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// upstream source and downstream sink
// ****************************************
module tpg_stream_model
#(
  parameter int W = 24,
  parameter int COLS = 8,
  parameter int ROWS = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic src_en_i,
  input wire logic slow_i,
  input wire logic s_ready_i,
  output logic s_valid_o,
  output logic [W-1:0] s_data_o,
  output logic s_user_o,
  output logic s_last_o,
  input wire logic m_valid_i,
  input wire logic [W-1:0] m_data_i,
  input wire logic m_user_i,
  input wire logic m_last_i,
  output logic m_ready_o,
  output int beats_o,
  output int users_o,
  output int lasts_o,
  output int bad_o,
  output logic [W-1:0] or_o
);
  int n;
  int e;
  logic ph;

  // source beat n carries counting data, framed COLS x ROWS
  always_comb
  begin
    s_valid_o = src_en_i;
    s_data_o = s_valid_o ? W'(n * 3 + 1) : ~W'(n * 3 - 2);
    s_user_o = s_valid_o && (n % (COLS * ROWS) == 0);
    s_last_o = s_valid_o && (n % COLS == COLS - 1);
    m_ready_o = slow_i ? ph : 1'b1;  // stall every other cycle
  end

  // count taken beats, compare pass data against source order
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      n <= 0;
      e <= 0;
      ph <= 1'b0;
      beats_o <= 0;
      users_o <= 0;
      lasts_o <= 0;
      bad_o <= 0;
      or_o <= '0;
    end
    else
    begin
      ph <= ~ph;
      if (s_valid_o && s_ready_i)
        n <= n + 1;
      if (m_valid_i && m_ready_o)
      begin
        beats_o <= beats_o + 1;
        users_o <= users_o + int'(m_user_i);
        lasts_o <= lasts_o + int'(m_last_i);
        or_o <= or_o | m_data_i;
        if (src_en_i)
        begin
          e <= e + 1;
          if (m_data_i !== W'(e * 3 + 1) ||
              m_user_i !== (e % (COLS * ROWS) == 0))
            bad_o <= bad_o + 1;
        end
      end
    end
  end
endmodule  // tpg_stream_model
`default_nettype wire

// ==== dv/tpg_core_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module tpg_core_test
  import tpg_pkg::*;
;
  localparam int W = 24;
  typedef struct packed
  {
    logic [7:0] adr;
    logic [31:0] wd;
    logic [31:0] rd;
  } tpg_row_t;
  logic clk, rst_n, cyc, stb, we, ack, src_en, slow;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic s_valid, s_ready, s_user, s_last, m_valid, m_ready, m_user, m_last;
  logic [W-1:0] s_data, m_data, or_v;
  int beats, users, lasts, bad, miscompares, checks_done, b0, l0, u0;
  tpg_row_t rows [10] = '{
    '{REG_WIDTH, 32'h0000_0008, 32'h0000_0008},
    '{REG_HEIGHT, 32'h0000_0002, 32'h0000_0002},
    '{REG_BG_SEL, 32'h0000_000a, 32'h0000_000a},
    '{REG_OVL_SEL, 32'h0000_0002, 32'h0000_0002},
    '{REG_CROSS_X, 32'h0000_0003, 32'h0000_0003},
    '{REG_CROSS_Y, 32'h0000_0001, 32'h0000_0001},
    '{REG_FORMAT, 32'h0000_0003, 32'h0000_0003},
    '{REG_SPEED, 32'h0000_0105, 32'h0000_0005},
    '{REG_STATUS, 32'hffff_ffff, 32'h0000_0000},
    '{8'h3c, 32'hffff_ffff, 32'h0000_0000}};

  // ****************************************
  // design, partner and clock
  // ****************************************
  tpg_core #(.HAS_ZONE(1'b0)) u_dut (.core_clock_i(clk),
    .core_reset_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .s_axis_tvalid_i(s_valid), .s_axis_tready_o(s_ready),
    .s_axis_tdata_i(s_data), .s_axis_tuser_i(s_user),
    .s_axis_tlast_i(s_last), .m_axis_tvalid_o(m_valid),
    .m_axis_tready_i(m_ready), .m_axis_tdata_o(m_data),
    .m_axis_tuser_o(m_user), .m_axis_tlast_o(m_last));
  tpg_stream_model #(.W(W)) u_model (.clk_i(clk), .rst_n_i(rst_n),
    .src_en_i(src_en), .slow_i(slow), .s_ready_i(s_ready),
    .s_valid_o(s_valid), .s_data_o(s_data), .s_user_o(s_user),
    .s_last_o(s_last), .m_valid_i(m_valid), .m_data_i(m_data),
    .m_user_i(m_user), .m_last_i(m_last), .m_ready_o(m_ready),
    .beats_o(beats), .users_o(users), .lasts_o(lasts), .bad_o(bad),
    .or_o(or_v));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20)
    begin
      miscompares++;
      $display("[ERR] %0t bus answer timed out", $time);
      finish_test();
    end
  endtask

  task automatic wait_lasts(input int target);
    int n;
    n = 0;
    while (lasts < target && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000)
    begin
      miscompares++;
      $display("[ERR] %0t line count timed out", $time);
      finish_test();
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    src_en = 1'b0;
    slow = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({31'h0, m_valid}, 32'h0);
    chk({31'h0, s_ready}, 32'h0);
    wb(1'b0, REG_WIDTH, 32'h0);
    chk(q, 32'h0000_0040);
    wb(1'b0, REG_HEIGHT, 32'h0);
    chk(q, 32'h0000_0040);
    foreach (rows[i])
    begin
      wb(1'b1, rows[i].adr, rows[i].wd);
      wb(1'b0, rows[i].adr, 32'h0);
      chk(q, rows[i].rd);
    end
    // omitted zone plate gives black, sink stalling
    wb(1'b1, REG_OVL_SEL, 32'(OVL_NONE));
    slow <= 1'b1;
    l0 = lasts;
    b0 = beats;
    u0 = users;
    wb(1'b1, REG_CTRL, 32'h1);
    wait_lasts(l0 + 2);
    chk(beats - b0, 16);
    chk(users - u0, 1);
    chk(32'(or_v), 32'h0);
    // background change while running
    wb(1'b1, REG_BG_SEL, 32'(PAT_WHITE));
    wait_lasts(lasts + 2);
    chk(32'(or_v != '0), 32'h1);
    wb(1'b1, REG_CTRL, 32'h0);
    b0 = 0;
    do
    begin
      wb(1'b0, REG_STATUS, 32'h0);
      b0++;
    end
    while (q[1:0] !== 2'b00 && b0 < 100);
    chk(32'(q[1:0]), 32'h0);
    // pass-through of the input stream
    slow <= 1'b0;
    wb(1'b1, REG_IN_EN, 32'h1);
    wb(1'b1, REG_BG_SEL, 32'(PAT_PASS));
    src_en <= 1'b1;
    l0 = lasts;
    u0 = users;
    wb(1'b1, REG_CTRL, 32'h1);
    wait_lasts(l0 + 4);
    chk(bad, 0);
    chk(users - u0, 2);
    // minimum reset in mid-frame
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    src_en <= 1'b0;
    repeat (16) @(posedge clk);
    chk({31'h0, m_valid}, 32'h0);
    chk({31'h0, s_ready}, 32'h0);
    rst_n <= 1'b1;
    wb(1'b0, REG_WIDTH, 32'h0);
    chk(q, 32'h0000_0040);
    chk(32'(or_v), 32'h0);
    // cross hair drawn over a black background
    wb(1'b1, REG_WIDTH, 32'h8);
    wb(1'b1, REG_HEIGHT, 32'h2);
    wb(1'b1, REG_BG_SEL, 32'(PAT_BLACK));
    wb(1'b1, REG_OVL_SEL, 32'(OVL_CROSS));
    wb(1'b1, REG_CROSS_X, 32'h3);
    wb(1'b1, REG_CTRL, 32'h1);
    wait_lasts(lasts + 2);
    chk(32'(or_v != '0), 32'h1);
    finish_test();
  end
endmodule  // tpg_core_test
`default_nettype wire
